/* File: ddwm_bank.sv */
// Purpose: Warning mask, panel display select and small drive settings
// Assumes: One-cycle strobes from a core_clk master; index addressing
// Notes: Reserved mask bits read as zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module ddwm_bank #(
  parameter int STEP_CNT = ddwm_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ddwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ddwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ddwm_pkg::DATA_W-1:0] reg_rdata,
  // Drive status
  input wire logic servo_on,
  input wire logic [7:0] elec_angle,
  input wire logic [7:0] zphase_count,
  input wire logic bus_err_pulse,
  input wire logic enc_err_pulse,
  input wire logic [7:0] node_switch,
  // Raw warnings, bit per mask position
  input wire logic [15:0] warn_raw,
  // Force limit sources
  input wire logic force_lim_incl,
  input wire logic force_lim_excl,
  // Outputs
  output logic [15:0] warn_active,
  output logic force_limit_flag,
  output logic backlash_enable,
  output logic backlash_negative,
  output logic [7:0] panel_digits,
  output logic irq
);
  import ddwm_pkg::*;
  // The step counter is 25 bits wide; a 100 ms step at 200 MHz needs more than 24
  if (STEP_CNT < 1 || STEP_CNT > 2 ** 25) begin : g_step_cnt_check
    $error("STEP_CNT must lie between 1 and 2**25");
  end
  typedef struct packed {
    logic [15:0] disp_sel;
    logic [15:0] show_time;
    logic force_sel;
    logic [1:0] backlash;
    logic [15:0] warn_mask;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [24:0] step_cnt;
    logic [15:0] steps;
    ddwm_disp_t disp;
    logic started;
    logic [7:0] sw_meta;
    logic [7:0] sw_mid;
    logic [7:0] sw_last;
    logic [1:0] sw_fill;
    logic [7:0] node_addr;
    logic [15:0] rdata;
    logic [15:0] warn_active;
    logic flag;
    logic bl_en;
    logic bl_neg;
    logic [7:0] digits;
    logic irq;
  } ddwm_state_t;
  ddwm_state_t st;
  ddwm_state_t next_st;
  logic [15:0] bus_cnt;
  logic [15:0] enc_cnt;
  logic bus_err_seen;
  logic enc_err_seen;
  ddwm_err_counter u_bus_cnt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .err_pulse(bus_err_pulse),
    .count(bus_cnt)
  );
  ddwm_err_counter u_enc_cnt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .err_pulse(enc_err_pulse),
    .count(enc_cnt)
  );
  assign bus_err_seen = bus_err_pulse;
  assign enc_err_seen = enc_err_pulse;
  // Binary to two BCD digits, values above 99 show low two digits
  function automatic logic [7:0] to_bcd(input logic [7:0] v);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = (v % 8'd100) / 8'd10;
    ones = v % 8'd10;
    return {tens[3:0], ones[3:0]};
  endfunction
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    return a == idx;
  endfunction
  logic [2:0] events;
  logic show_done;
  logic [7:0] sel_digits;
  always_comb begin
    next_st = st;
    show_done = 1'b0;
    events = 3'b000;
    sel_digits = SEG_BLANK;
    // Rotary switch is a pin: three stages, and only the last two are compared
    next_st.sw_meta = node_switch;
    next_st.sw_mid = st.sw_meta;
    next_st.sw_last = st.sw_mid;
    if (reg_wr) begin
      if (hit(reg_addr, IDX_DISPLAY_SEL)) begin
        next_st.disp_sel = reg_wdata;
      end
      if (hit(reg_addr, IDX_ADDR_SHOW) && reg_wdata <= ADDR_SHOW_MAX) begin
        next_st.show_time = reg_wdata;
      end
      if (hit(reg_addr, IDX_FORCE_FLAG) && reg_wdata[15:1] == 15'h0000) begin
        next_st.force_sel = reg_wdata[0];
      end
      if (hit(reg_addr, IDX_BACKLASH) && reg_wdata <= BACKLASH_MAX) begin
        next_st.backlash = reg_wdata[1:0];
      end
      if (hit(reg_addr, IDX_WARN_MASK)) begin
        next_st.warn_mask = reg_wdata & WARN_VALID;
      end
      if (hit(reg_addr, IDX_IRQ_STATUS)) begin
        next_st.irq_status = st.irq_status & ~reg_wdata[2:0];
      end
      if (hit(reg_addr, IDX_IRQ_MASK)) begin
        next_st.irq_mask = reg_wdata[2:0];
      end
    end
    // Node address caught once the stages have filled and agree; later moves ignored
    if (!st.started) begin
      if (st.sw_fill != 2'd3) begin
        next_st.sw_fill = st.sw_fill + 2'd1;
      end else if (st.sw_mid == st.sw_last) begin
        next_st.started = 1'b1;
        next_st.node_addr = st.sw_last;
      end
    end
    // Address display timer; the divider keeps the step counter narrow
    if (st.disp == DDWM_SHOW_ADDR && st.started) begin
      if (st.steps >= st.show_time) begin
        next_st.disp = DDWM_SHOW_SEL;
        show_done = 1'b1;
      end else if (st.step_cnt == 25'(STEP_CNT - 1)) begin
        next_st.step_cnt = '0;
        next_st.steps = st.steps + 16'h0001;
      end else begin
        next_st.step_cnt = st.step_cnt + 25'h000_0001;
      end
    end
    events[IRQ_BUS_ERR] = bus_err_seen;
    events[IRQ_ENC_ERR] = enc_err_seen;
    events[IRQ_SHOW_DONE] = show_done;
    // Set wins over a clear in the same cycle
    next_st.irq_status = next_st.irq_status | events;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    unique case (st.disp_sel[3:0])
      SEL_NORMAL: sel_digits = servo_on ? 8'h00 : SEG_BLANK;
      SEL_ANGLE: sel_digits = elec_angle;
      SEL_BUS_ERR: sel_digits = bus_cnt[7:0];
      SEL_NODE: sel_digits = to_bcd(st.node_addr);
      SEL_ENC_ERR: sel_digits = enc_cnt[7:0];
      SEL_ZPHASE: sel_digits = zphase_count;
      default: sel_digits = SEG_BLANK;
    endcase
    if (st.disp_sel[15:4] != 12'h000) begin
      sel_digits = SEG_BLANK;
    end
    // Blank until the switch value is caught, so no false address flashes up
    if (!next_st.started) begin
      next_st.digits = SEG_BLANK;
    end else begin
      next_st.digits = (next_st.disp == DDWM_SHOW_ADDR) ? to_bcd(next_st.node_addr) : sel_digits;
    end
    // Mask bit set suppresses detection
    next_st.warn_active = warn_raw & WARN_VALID & ~st.warn_mask;
    next_st.flag = st.force_sel ? force_lim_excl : force_lim_incl;
    next_st.bl_en = st.backlash != 2'd0;
    next_st.bl_neg = st.backlash == 2'd2;
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      if (hit(reg_addr, IDX_DISPLAY_SEL)) begin
        next_st.rdata = st.disp_sel;
      end else if (hit(reg_addr, IDX_ADDR_SHOW)) begin
        next_st.rdata = st.show_time;
      end else if (hit(reg_addr, IDX_FORCE_FLAG)) begin
        next_st.rdata = {15'h0000, st.force_sel};
      end else if (hit(reg_addr, IDX_BACKLASH)) begin
        next_st.rdata = {14'h0000, st.backlash};
      end else if (hit(reg_addr, IDX_WARN_MASK)) begin
        next_st.rdata = st.warn_mask;
      end else if (hit(reg_addr, IDX_IRQ_STATUS)) begin
        next_st.rdata = {13'h0000, st.irq_status};
      end else if (hit(reg_addr, IDX_IRQ_MASK)) begin
        next_st.rdata = {13'h0000, st.irq_mask};
      end else if (hit(reg_addr, IDX_DISP_NOW)) begin
        next_st.rdata = {7'h00, st.disp, st.digits};
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.disp_sel <= RST_DISPLAY_SEL;
      st.show_time <= RST_ADDR_SHOW;
      st.force_sel <= RST_FORCE_FLAG[0];
      st.backlash <= RST_BACKLASH[1:0];
      st.warn_mask <= RST_WARN_MASK;
      st.disp <= DDWM_SHOW_ADDR;
      st.digits <= SEG_BLANK;
    end else begin
      st <= next_st;
    end
  end
  assign reg_rdata = st.rdata;
  assign warn_active = st.warn_active;
  assign force_limit_flag = st.flag;
  assign backlash_enable = st.bl_en;
  assign backlash_negative = st.bl_neg;
  assign panel_digits = st.digits;
  assign irq = st.irq;
  sequence s_mask_written;
    reg_wr && reg_addr == IDX_WARN_MASK;
  endsequence
  sequence s_address_phase;
    st.started && st.disp == DDWM_SHOW_ADDR;
  endsequence
  chk_mask_blocks_warn: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mask_written ##1 1'b1 |=> (warn_active & $past(reg_wdata, 2)) == 16'h0000)
    else $error("masked warning still active");
  chk_mask_life_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_LIFE] && warn_raw[WB_LIFE] |=> warn_active[WB_LIFE])
    else $error("life warning lost while unmasked");
  chk_reserved_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    (warn_active & ~WARN_VALID) == 16'h0000)
    else $error("reserved warning bit active");
  chk_backlash_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == IDX_BACKLASH && reg_wdata > BACKLASH_MAX |=> $stable(st.backlash))
    else $error("backlash took illegal value");
  chk_backlash_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.backlash == 2'd2 |=> backlash_enable && backlash_negative)
    else $error("backlash negative not driven");
  chk_force_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.force_sel && $stable(st.force_sel) |=> force_limit_flag == $past(force_lim_excl))
    else $error("force flag source wrong");
  chk_normal_servo_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == 16'h0000 && servo_on |=> panel_digits == 8'h00)
    else $error("normal display not 00");
  chk_zero_time_switch: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.started && st.disp == DDWM_SHOW_ADDR && st.show_time == 16'h0000 |=> st.disp == DDWM_SHOW_SEL)
    else $error("zero display time not immediate");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == |(st.irq_status & st.irq_mask))
    else $error("interrupt level mismatch");
  // Warning gating per mask bit
  chk_regen_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_REGEN] && warn_raw[WB_REGEN] |=> warn_active[WB_REGEN])
    else $error("regeneration warning lost while unmasked");
  chk_fan_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_FAN] && warn_raw[WB_FAN] |=> warn_active[WB_FAN])
    else $error("fan warning lost while unmasked");
  chk_overload_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_OVERLOAD] && warn_raw[WB_OVERLOAD] |=> warn_active[WB_OVERLOAD])
    else $error("overload warning lost while unmasked");
  chk_enc_vib_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_ENC_WARN] && !st.warn_mask[WB_VIBRATION] && warn_raw[WB_ENC_WARN] && warn_raw[WB_VIBRATION]
    |=> warn_active[WB_ENC_WARN] && warn_active[WB_VIBRATION])
    else $error("encoder or vibration warning lost while unmasked");
  chk_enc_comm_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.warn_mask[WB_ENC_COMM] && warn_raw[WB_ENC_COMM] |=> warn_active[WB_ENC_COMM])
    else $error("encoder link warning lost while unmasked");
  // Display path: each selection reaches the panel one cycle later
  chk_blank_servo_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == 16'h0000 && !servo_on |=> panel_digits == SEG_BLANK)
    else $error("normal display not blank");
  chk_angle_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == {12'h000, SEL_ANGLE} |=> panel_digits == $past(elec_angle))
    else $error("angle not on display");
  chk_bus_count_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == {12'h000, SEL_BUS_ERR} |=> panel_digits == $past(bus_cnt[7:0]))
    else $error("bus error count not on display");
  chk_enc_count_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == {12'h000, SEL_ENC_ERR} |=> panel_digits == $past(enc_cnt[7:0]))
    else $error("encoder error count not on display");
  chk_node_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.started |=> $stable(st.node_addr))
    else $error("node address followed the switch");
  chk_zphase_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && st.disp_sel == {12'h000, SEL_ZPHASE} |=> panel_digits == $past(zphase_count))
    else $error("z count not on display");
  chk_reserved_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL && (st.disp_sel == 16'h0001 || st.disp_sel == 16'h0005 || st.disp_sel > 16'h0007)
    |=> panel_digits == SEG_BLANK)
    else $error("reserved selection not blank");
  chk_address_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_address_phase ##0 (st.steps < st.show_time) |=> st.disp == DDWM_SHOW_ADDR)
    else $error("address display ended early");
  chk_show_time_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.show_time <= ADDR_SHOW_MAX)
    else $error("address display time out of range");
  chk_step_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
    {1'b0, st.step_cnt} < 26'(STEP_CNT))
    else $error("step divider overran");
  chk_sel_sticks: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.disp == DDWM_SHOW_SEL |=> st.disp == DDWM_SHOW_SEL)
    else $error("display went back to address");
  chk_address_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_address_phase ##0 (st.steps >= st.show_time) |=> st.disp == DDWM_SHOW_SEL && st.irq_status[IRQ_SHOW_DONE])
    else $error("address display did not hand over");
  // Settings and bus
  chk_backlash_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == IDX_BACKLASH && reg_wdata <= BACKLASH_MAX |=> st.backlash == $past(reg_wdata[1:0]))
    else $error("legal backlash value not taken");
  chk_force_incl: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.force_sel |=> force_limit_flag == $past(force_lim_incl))
    else $error("force flag not from including source");
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_event_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_err_pulse |=> st.irq_status[IRQ_BUS_ERR])
    else $error("bus error event not latched");
endmodule // ddwm_bank

/* File: ddwm_bank_tb_top.sv */
// Purpose: Self-checking bench for the display, mask and settings bank
// Assumes: STEP_CNT shortened to 4 cycles
// Notes: Counter saturation is not reached; it would cost 65535 pulses
`timescale 1ns/100ps
module ddwm_bank_tb_top;
  import ddwm_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, servo_on, bus_err_pulse, enc_err_pulse;
  logic force_lim_incl, force_lim_excl, force_limit_flag, backlash_enable, backlash_negative, irq;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, warn_raw, warn_active, rv;
  logic [7:0] elec_angle, zphase_count, node_switch, panel_digits;
  int n_errors, n_tests;
  int bits [7] = '{WB_LIFE, WB_REGEN, WB_FAN, WB_OVERLOAD, WB_ENC_WARN, WB_VIBRATION, WB_ENC_COMM};
  always #2.5 core_clk = ~core_clk;
  ddwm_master u_ddwm_master (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ddwm_bank #(.STEP_CNT(4)) u_ddwm_bank (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .servo_on(servo_on), .elec_angle(elec_angle), .zphase_count(zphase_count),
    .bus_err_pulse(bus_err_pulse), .enc_err_pulse(enc_err_pulse), .node_switch(node_switch),
    .warn_raw(warn_raw), .force_lim_incl(force_lim_incl), .force_lim_excl(force_lim_excl),
    .warn_active(warn_active), .force_limit_flag(force_limit_flag), .backlash_enable(backlash_enable),
    .backlash_negative(backlash_negative), .panel_digits(panel_digits), .irq(irq));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic rchk(input string name, input logic [15:0] a, input logic [15:0] exp);
    u_ddwm_master.rd(a, rv);
    chk(name, exp, rv);
  endtask
  // Two register stages sit between a write and the outputs, except irq, which follows after one
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic show(input string name, input logic [7:0] exp);
    settle();
    chk(name, {8'h00, exp}, {8'h00, panel_digits});
  endtask
  task automatic pulse(input bit enc);
    @(posedge core_clk);
    if (enc) enc_err_pulse <= 1'b1;
    else bus_err_pulse <= 1'b1;
    @(posedge core_clk);
    enc_err_pulse <= 1'b0;
    bus_err_pulse <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {servo_on, bus_err_pulse, enc_err_pulse, force_lim_incl} = 4'h0;
    force_lim_excl = 1'b1;
    elec_angle = 8'hA5;
    zphase_count = 8'h3C;
    node_switch = 8'd37;
    warn_raw = 16'hFFFF;
    do_reset();
    rchk("display select", IDX_DISPLAY_SEL, RST_DISPLAY_SEL);
    rchk("show time", IDX_ADDR_SHOW, RST_ADDR_SHOW);
    rchk("force select", IDX_FORCE_FLAG, RST_FORCE_FLAG);
    rchk("backlash", IDX_BACKLASH, RST_BACKLASH);
    rchk("warn mask", IDX_WARN_MASK, RST_WARN_MASK);
    rchk("unmapped", 16'h3702, 16'h0000);
    chk("warn reset", WARN_VALID & ~RST_WARN_MASK, warn_active);
    foreach (bits[i]) begin
      u_ddwm_master.wr(IDX_WARN_MASK, 16'h0001 << bits[i]);
      settle();
      chk("warn one masked", WARN_VALID & ~(16'h0001 << bits[i]), warn_active);
    end
    show("blank servo off", SEG_BLANK);
    @(posedge core_clk);
    servo_on <= 1'b1;
    show("servo on", 8'h00);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0005);
    show("reserved select", SEG_BLANK);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0002);
    show("angle", 8'hA5);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0007);
    show("z count", 8'h3C);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0004);
    node_switch <= 8'd99;
    show("node", 8'h37);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0003);
    repeat (3) pulse(1'b0);
    show("bus errors", 8'h03);
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0006);
    repeat (2) pulse(1'b1);
    show("enc errors", 8'h02);
    rchk("display now", IDX_DISP_NOW, 16'h0102);
    u_ddwm_master.wr(IDX_IRQ_MASK, 16'h0001);
    settle();
    chk("irq raised", 16'h0001, {15'h0000, irq});
    u_ddwm_master.wr(IDX_IRQ_STATUS, 16'h0001);
    settle();
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rchk("irq status", IDX_IRQ_STATUS, 16'h0006);
    chk("force excl", 16'h0001, {15'h0000, force_limit_flag});
    u_ddwm_master.wr(IDX_FORCE_FLAG, 16'h0000);
    settle();
    chk("force incl low", 16'h0000, {15'h0000, force_limit_flag});
    @(posedge core_clk);
    force_lim_incl <= 1'b1;
    settle();
    chk("force incl high", 16'h0001, {15'h0000, force_limit_flag});
    u_ddwm_master.wr(IDX_FORCE_FLAG, 16'h0002);
    rchk("force refused", IDX_FORCE_FLAG, 16'h0000);
    for (int v = 0; v < 3; v++) begin
      u_ddwm_master.wr(IDX_BACKLASH, 16'(v));
      settle();
      chk("backlash out", {14'h0000, v == 2, v != 0}, {14'h0000, backlash_negative, backlash_enable});
    end
    u_ddwm_master.wr(IDX_BACKLASH, 16'h0003);
    rchk("backlash refused", IDX_BACKLASH, 16'h0002);
    u_ddwm_master.wr(IDX_ADDR_SHOW, ADDR_SHOW_MAX);
    u_ddwm_master.wr(IDX_ADDR_SHOW, 16'h03E9);
    rchk("show time max", IDX_ADDR_SHOW, ADDR_SHOW_MAX);
    do_reset();
    u_ddwm_master.wr(IDX_DISPLAY_SEL, 16'h0003);
    show("errors cleared", 8'h00);
    conclude();
  end
endmodule // ddwm_bank_tb_top

/* File: ddwm_err_counter.sv */
// Purpose: Saturating cumulative communications error counter
// Assumes: Error pulses come from core_clk logic
// Notes: Cleared only by reset, i.e. at control power-up
`timescale 1ns/100ps
module ddwm_err_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Event
  input wire logic err_pulse,
  // Count
  output logic [15:0] count
);
  import ddwm_pkg::*;
  typedef struct packed {
    logic [15:0] count;
  } ddwm_cnt_state_t;
  ddwm_cnt_state_t st;
  ddwm_cnt_state_t next_st;
  always_comb begin
    next_st = st;
    if (err_pulse && st.count != CNT_SAT) begin
      next_st.count = st.count + 16'h0001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign count = st.count;
  chk_count_saturates: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(count) == CNT_SAT |-> count == CNT_SAT)
    else $error("error counter left saturation");
  chk_count_steps: assert property (@(posedge core_clk) disable iff (!rst_n)
    err_pulse && count != CNT_SAT |=> count == $past(count) + 16'h0001)
    else $error("error counter missed an event");
endmodule // ddwm_err_counter

/* File: ddwm_master.sv */
// Purpose: Register master model that writes the drive configuration objects
// Assumes: Strobes one cycle long, changed just after a rising edge
// Notes: Read data are taken only in the single cycle after the strobe
`timescale 1ns/100ps
module ddwm_master (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [ddwm_pkg::ADDR_W-1:0] reg_addr,
  output logic [ddwm_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [ddwm_pkg::DATA_W-1:0] reg_rdata
);
  import ddwm_pkg::*;
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    // Reserved mask positions always go out as zero
    reg_wdata <= (a == IDX_WARN_MASK) ? (d & WARN_VALID) : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // ddwm_master

/* File: ddwm_pkg.sv */
// Purpose: Shared constants for the drive display and warning mask bank
// Assumes: 16-bit register port, 200 MHz core clock
// Notes: Offsets are object indices; byte address is four times the index
package ddwm_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] IDX_DISPLAY_SEL = 16'h3700;
  localparam logic [15:0] IDX_ADDR_SHOW = 16'h3701;
  localparam logic [15:0] IDX_FORCE_FLAG = 16'h3703;
  localparam logic [15:0] IDX_BACKLASH = 16'h3704;
  localparam logic [15:0] IDX_WARN_MASK = 16'h3638;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h3710;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h3711;
  localparam logic [15:0] IDX_DISP_NOW = 16'h3712;
  localparam logic [15:0] RST_DISPLAY_SEL = 16'h0000;
  localparam logic [15:0] RST_ADDR_SHOW = 16'h0000;
  localparam logic [15:0] RST_FORCE_FLAG = 16'h0001;
  localparam logic [15:0] RST_BACKLASH = 16'h0000;
  localparam logic [15:0] RST_WARN_MASK = 16'h0004;
  localparam logic [15:0] WARN_VALID = 16'h07E4;
  localparam logic [15:0] ADDR_SHOW_MAX = 16'h03E8;
  localparam logic [15:0] BACKLASH_MAX = 16'h0002;
  localparam int WB_LIFE = 2;
  localparam int WB_REGEN = 5;
  localparam int WB_FAN = 6;
  localparam int WB_OVERLOAD = 7;
  localparam int WB_ENC_WARN = 8;
  localparam int WB_VIBRATION = 9;
  localparam int WB_ENC_COMM = 10;
  localparam logic [3:0] SEL_NORMAL = 4'h0;
  localparam logic [3:0] SEL_ANGLE = 4'h2;
  localparam logic [3:0] SEL_BUS_ERR = 4'h3;
  localparam logic [3:0] SEL_NODE = 4'h4;
  localparam logic [3:0] SEL_ENC_ERR = 4'h6;
  localparam logic [3:0] SEL_ZPHASE = 4'h7;
  localparam logic [7:0] SEG_BLANK = 8'hFF;
  localparam logic [15:0] CNT_SAT = 16'hFFFF;
  localparam int IRQ_BUS_ERR = 0;
  localparam int IRQ_ENC_ERR = 1;
  localparam int IRQ_SHOW_DONE = 2;
  localparam int CLK_MHZ = 200;
  localparam int STEP_MS = 100;
  localparam int STEP_CYCLES = STEP_MS * 1000 * CLK_MHZ;
  typedef enum logic [0:0] {
    DDWM_SHOW_ADDR = 1'b0,
    DDWM_SHOW_SEL = 1'b1
  } ddwm_disp_t;
endpackage
